// >>> hdl/pbwc_pkg.sv
// Shared constants and types of the push-button wiper counter
package pbwc_pkg;
   // Wiper geometry
   localparam int unsigned POS_W = 5;
   localparam int unsigned TAPS = 32;
   localparam logic [4:0] POS_MAX = 5'h1f;
   localparam logic [4:0] POS_MIN = 5'h00;
   // Clock rate
   localparam int unsigned CLK_HZ = 40_000_000;
   // Times in their own units, then cycle counts
   localparam int unsigned DEBOUNCE_MS = 40;
   localparam int unsigned DEBOUNCE_CYC = CLK_HZ / 1000 * DEBOUNCE_MS;
   localparam int unsigned HOLD_S = 1;
   localparam int unsigned HOLD_CYC = CLK_HZ * HOLD_S;
   localparam int unsigned SLOW_MS = 250;
   localparam int unsigned SLOW_CYC = CLK_HZ / 1000 * SLOW_MS;
   localparam int unsigned FAST_MS = 50;
   localparam int unsigned FAST_CYC = CLK_HZ / 1000 * FAST_MS;
   localparam int unsigned GAP_US = 50;
   // Cycles after reset before the strap and stored value are taken
   localparam logic [1:0] INIT_WAIT = 2'h3;
   // Input lanes of the debouncer bank
   localparam int unsigned IN_UP = 0;
   localparam int unsigned IN_DN = 1;
   localparam int unsigned IN_SE = 2;
   localparam int unsigned N_IN = 3;
   // Scan state, Gray along idle, slow, fast
   typedef enum logic [1:0] {
      PBWC_IDLE = 2'h0,
      PBWC_SLOW = 2'h1,
      PBWC_FAST = 2'h3
   } pbwc_state_t;
endpackage

// >>> hdl/pbwc_debounce.sv
// Two-flop synchroniser and debounce filter for one active-low pin
`timescale 1ns/100ps
`default_nettype none
module pbwc_debounce #(
   parameter int unsigned CNT = pbwc_pkg::DEBOUNCE_CYC
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic srst_i,
   // Pin side
   input wire logic pin_i,
   // Filtered side
   output logic sync_o,
   output logic level_o
);
   import pbwc_pkg::*;

   logic s1_r, s2_r, s1_nxt, s2_nxt;
   logic lvl_r, lvl_nxt;
   logic [31:0] cnt_r, cnt_nxt;

   // Count while the synced pin differs from the settled level
   always_comb begin
      s1_nxt = pin_i;
      s2_nxt = s1_r;
      lvl_nxt = lvl_r;
      cnt_nxt = 32'h0000_0000;
      if (s2_r != lvl_r) begin
         cnt_nxt = cnt_r + 32'h0000_0001;
         if (cnt_r == CNT - 1) begin
            lvl_nxt = s2_r;
            cnt_nxt = 32'h0000_0000;
         end
      end
   end

   // Idle level is high, as the pull-up leaves it
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         s1_r <= 1'b1;
         s2_r <= 1'b1;
         lvl_r <= 1'b1;
         cnt_r <= 32'h0000_0000;
      end else begin
         s1_r <= s1_nxt;
         s2_r <= s2_nxt;
         lvl_r <= lvl_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   assign sync_o = s2_r;
   assign level_o = lvl_r;

   // A settled level only moves after a full interval of disagreement
   db_settle_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      (lvl_r != $past(lvl_r)) |-> ($past(cnt_r) == CNT - 1))
      else $error("debounced level changed before the interval ran out");
endmodule
`default_nettype wire

// >>> hdl/pbwc_top.sv
// Push-button wiper counter: debounce, scan, saturating count, tap decode, store
`timescale 1ns/100ps
`default_nettype none
module pbwc_top #(
   parameter int unsigned DEBOUNCE_N = pbwc_pkg::DEBOUNCE_CYC,
   parameter int unsigned HOLD_N = pbwc_pkg::HOLD_CYC,
   parameter int unsigned SLOW_N = pbwc_pkg::SLOW_CYC,
   parameter int unsigned FAST_N = pbwc_pkg::FAST_CYC
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic srst_i,
   // Push-button pins, active low
   input wire logic step_up_n_i,
   input wire logic step_down_n_i,
   input wire logic store_enable_n_i,
   // Supply monitor, high when the supply is falling
   input wire logic supply_fail_i,
   // Nonvolatile memory port
   input wire logic [pbwc_pkg::POS_W-1:0] nv_rdata_i,
   output logic nv_wr_o,
   output logic [pbwc_pkg::POS_W-1:0] nv_wdata_o,
   // Wiper outputs
   output logic [pbwc_pkg::POS_W-1:0] wiper_pos_o,
   output logic [pbwc_pkg::TAPS-1:0] tap_sel_o,
   output logic scan_fast_o
);
   import pbwc_pkg::*;

   // One-hot switch pattern for a wiper position
   function automatic logic [TAPS-1:0] tap_decode(input logic [POS_W-1:0] pos);
      logic [TAPS-1:0] t;
      t = '0;
      t[pos] = 1'b1;
      return t;
   endfunction

   // Debouncer bank, one lane per pin
   logic [N_IN-1:0] pin_raw, pin_sync, pin_db;
   assign pin_raw = {store_enable_n_i, step_down_n_i, step_up_n_i};

   genvar gi;
   generate
      for (gi = 0; gi < N_IN; gi++) begin : g_db
         pbwc_debounce #(
            .CNT(DEBOUNCE_N)
         ) u_db (
            .clk_sys_i(clk_sys_i),
            .srst_i(srst_i),
            .pin_i(pin_raw[gi]),
            .sync_o(pin_sync[gi]),
            .level_o(pin_db[gi])
         );
      end
   endgenerate

   logic up_db, dn_db, se_db;
   assign up_db = pin_db[IN_UP];
   assign dn_db = pin_db[IN_DN];
   assign se_db = pin_db[IN_SE];

   // Power-up group: wait for the synchronisers, then take strap and stored value
   logic [1:0] init_cnt_r, init_cnt_nxt;
   logic init_done_r, init_done_nxt;
   logic se_pwr_hi_r, se_pwr_hi_nxt;

   always_comb begin
      init_cnt_nxt = init_cnt_r;
      init_done_nxt = init_done_r;
      se_pwr_hi_nxt = se_pwr_hi_r;
      if (!init_done_r) begin
         init_cnt_nxt = init_cnt_r + 2'h1;
         if (init_cnt_r == INIT_WAIT) begin
            init_done_nxt = 1'b1;
            se_pwr_hi_nxt = pin_sync[IN_SE];
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         init_cnt_r <= 2'h0;
         init_done_r <= 1'b0;
         se_pwr_hi_r <= 1'b0;
      end else begin
         init_cnt_r <= init_cnt_nxt;
         init_done_r <= init_done_nxt;
         se_pwr_hi_r <= se_pwr_hi_nxt;
      end
   end

   // Press qualification
   logic lock, press_up, press_dn, press, dir_chg;
   logic dir_up_r, dir_up_nxt;
   // Strapped high then pulled low: buttons are dead until it is high again
   assign lock = !init_done_r || (se_pwr_hi_r && !se_db);
   // Both low at once is no press at all
   assign press_up = !up_db && dn_db && !lock;
   assign press_dn = !dn_db && up_db && !lock;
   assign press = press_up || press_dn;
   assign dir_chg = press && (press_up != dir_up_r);

   // Scan group: idle, slow repeat, fast repeat
   pbwc_state_t state_r, state_nxt;
   logic [31:0] rep_r, rep_nxt, hold_r, hold_nxt;
   logic step;

   always_comb begin
      state_nxt = state_r;
      rep_nxt = rep_r + 32'h0000_0001;
      hold_nxt = hold_r + 32'h0000_0001;
      dir_up_nxt = dir_up_r;
      step = 1'b0;
      case (state_r)
         PBWC_IDLE: begin
            rep_nxt = 32'h0000_0000;
            hold_nxt = 32'h0000_0000;
            if (press) begin
               step = 1'b1;
               dir_up_nxt = press_up;
               state_nxt = PBWC_SLOW;
            end
         end
         PBWC_SLOW: begin
            if (!press || dir_chg) begin
               state_nxt = PBWC_IDLE;
            end else begin
               if (rep_r == SLOW_N - 1) begin
                  step = 1'b1;
                  rep_nxt = 32'h0000_0000;
               end
               if (hold_r == HOLD_N - 1) begin
                  state_nxt = PBWC_FAST;
                  rep_nxt = 32'h0000_0000;
               end
            end
         end
         PBWC_FAST: begin
            hold_nxt = hold_r;
            if (!press || dir_chg) begin
               state_nxt = PBWC_IDLE;
            end else if (rep_r == FAST_N - 1) begin
               step = 1'b1;
               rep_nxt = 32'h0000_0000;
            end
         end
         default: begin
            state_nxt = PBWC_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         state_r <= PBWC_IDLE;
         rep_r <= 32'h0000_0000;
         hold_r <= 32'h0000_0000;
         dir_up_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         rep_r <= rep_nxt;
         hold_r <= hold_nxt;
         dir_up_r <= dir_up_nxt;
      end
   end

   // Counter group: recall once, then saturating steps
   logic [POS_W-1:0] pos_r, pos_nxt;
   logic [TAPS-1:0] tap_r, tap_nxt;

   always_comb begin
      pos_nxt = pos_r;
      if (!init_done_r) begin
         if (init_cnt_r == INIT_WAIT) begin
            pos_nxt = nv_rdata_i;
         end
      end else if (step) begin
         // Direction comes from the live press, so the first step is right
         if (press_up && pos_r != POS_MAX) begin
            pos_nxt = pos_r + 5'h01;
         end else if (press_dn && pos_r != POS_MIN) begin
            pos_nxt = pos_r - 5'h01;
         end
      end
      tap_nxt = tap_decode(pos_nxt);
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         pos_r <= 5'h00;
         tap_r <= 32'h0000_0001;
      end else begin
         pos_r <= pos_nxt;
         tap_r <= tap_nxt;
      end
   end

   // Store group: supply-loss save when low, manual save on rising edge when high
   logic sf_s1_r, sf_s2_r, sf_prev_r, se_prev_r;
   logic sf_s1_nxt, sf_s2_nxt, sf_prev_nxt, se_prev_nxt;
   logic nv_wr_r, nv_wr_nxt;
   logic [POS_W-1:0] nv_wdata_r, nv_wdata_nxt;
   logic sf_rise, se_rise;

   assign sf_rise = sf_s2_r && !sf_prev_r;
   assign se_rise = se_db && !se_prev_r;

   always_comb begin
      sf_s1_nxt = supply_fail_i;
      sf_s2_nxt = sf_s1_r;
      sf_prev_nxt = sf_s2_r;
      se_prev_nxt = se_db;
      nv_wr_nxt = 1'b0;
      nv_wdata_nxt = nv_wdata_r;
      // The settled level picks the save mode
      if (init_done_r && ((sf_rise && !se_db) || se_rise)) begin
         nv_wr_nxt = 1'b1;
         nv_wdata_nxt = pos_r;
      end
   end

   // Store-enable history starts high so a strap does not fake an edge
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         sf_s1_r <= 1'b0;
         sf_s2_r <= 1'b0;
         sf_prev_r <= 1'b0;
         se_prev_r <= 1'b1;
         nv_wr_r <= 1'b0;
         nv_wdata_r <= 5'h00;
      end else begin
         sf_s1_r <= sf_s1_nxt;
         sf_s2_r <= sf_s2_nxt;
         sf_prev_r <= sf_prev_nxt;
         se_prev_r <= se_prev_nxt;
         nv_wr_r <= nv_wr_nxt;
         nv_wdata_r <= nv_wdata_nxt;
      end
   end

   assign nv_wr_o = nv_wr_r;
   assign nv_wdata_o = nv_wdata_r;
   assign wiper_pos_o = pos_r;
   assign tap_sel_o = tap_r;
   assign scan_fast_o = (state_r == PBWC_FAST);

   // Exactly one switch, and it matches the position
   tap_onehot_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      $onehot(tap_sel_o) && tap_sel_o == tap_decode(wiper_pos_o))
      else $error("tap select is not the decoded wiper position");

   step_up_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      (init_done_r && step && press_up && pos_r != POS_MAX) |=>
      (wiper_pos_o == $past(pos_r) + 5'h01))
      else $error("up step did not add one");

   sat_bounds_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      (init_done_r && ((pos_r == POS_MAX && !press_dn) || (pos_r == POS_MIN && !press_up)))
      |=> (wiper_pos_o == $past(pos_r)))
      else $error("wiper moved past an end");

   both_low_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      (!up_db && !dn_db && init_done_r) |=> (wiper_pos_o == $past(pos_r)))
      else $error("position moved with both buttons low");

   // A scan that is running when the lock starts may still show fast for that one cycle
   lock_hold_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      (init_done_r && se_pwr_hi_r && !se_db) |-> (!step ##1
      (state_r == PBWC_IDLE && wiper_pos_o == $past(pos_r))))
      else $error("wiper moved while store-enable lock was on");

   go_fast_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      (state_r == PBWC_SLOW && press && !dir_chg && hold_r == HOLD_N - 1) |=> scan_fast_o)
      else $error("did not enter fast scan after the hold time");

   release_idle_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      (state_r != PBWC_IDLE && !press) |=> (state_r == PBWC_IDLE && !scan_fast_o))
      else $error("scan did not stop on release");

   manual_save_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      (init_done_r && se_rise) |=> (nv_wr_o && nv_wdata_o == $past(pos_r)) ##1 !nv_wr_o)
      else $error("manual save did not write the position once");

   loss_save_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      (init_done_r && sf_rise && !se_db) |=> nv_wr_o)
      else $error("supply loss did not trigger a save");

   recall_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      (!init_done_r && init_cnt_r == INIT_WAIT) |=> (wiper_pos_o == $past(nv_rdata_i)))
      else $error("stored position was not recalled");
endmodule
`default_nettype wire

// >>> testbench/pbwc_buttons.sv
// Behavioural push-button and logic-level driver for the wiper counter pins
`timescale 1ns/100ps
`default_nettype none
module pbwc_buttons #(
   parameter int unsigned GAP_N = 2000
) (
   // Clock
   input wire logic clk_sys_i,
   // Press requests from the bench, bit 0 up, bit 1 down, bit 2 store
   input wire logic [2:0] req_i,
   // Pins, pulled high while released
   output logic step_up_n_o,
   output logic step_down_n_o,
   output logic store_enable_n_o,
   // A new push may start
   output logic ready_o
);
   logic [2:0] pin_n_r = 3'h7;
   logic [2:0] pin_n_nxt;
   int unsigned gap_r = 0;
   int unsigned gap_nxt;
   // Release is immediate, a new low waits out the gap since the last release
   always_comb begin
      pin_n_nxt = pin_n_r;
      gap_nxt = (gap_r < GAP_N) ? gap_r + 1 : gap_r;
      for (int i = 0; i < 3; i++) begin
         if (!req_i[i]) begin
            pin_n_nxt[i] = 1'b1;
            if (!pin_n_r[i]) gap_nxt = 0;
         end else if (pin_n_r[i] && gap_r >= GAP_N) begin
            pin_n_nxt[i] = 1'b0;
         end
      end
   end
   // Register the pins and the gap count
   always_ff @(posedge clk_sys_i) begin
      pin_n_r <= pin_n_nxt;
      gap_r <= gap_nxt;
   end
   assign step_up_n_o = pin_n_r[0];
   assign step_down_n_o = pin_n_r[1];
   assign store_enable_n_o = pin_n_r[2];
   assign ready_o = (gap_r >= GAP_N);
endmodule
`default_nettype wire

// >>> testbench/tb.sv
// Self-checking bench of the push-button wiper counter
`timescale 1ns/100ps
`default_nettype none
module tb;
   import pbwc_pkg::*;
   // Shortened counts keep the run small; FAST < SLOW < HOLD
   localparam int unsigned DEB = 4;
   localparam int unsigned HOLD = 200;
   localparam int unsigned SLOW = 40;
   localparam int unsigned FAST = 10;
   logic clk_sys_i = 1'b0;
   logic srst_i = 1'b1;
   logic supply_fail_i = 1'b0;
   logic [POS_W-1:0] nv_rdata_i = 5'h1e;
   logic [2:0] req = 3'h0;
   wire logic up_n, dn_n, se_n, ready, nv_wr, scan_fast;
   wire logic [POS_W-1:0] nv_wdata, wiper_pos;
   wire logic [TAPS-1:0] tap_sel;
   int mismatches = 0;
   int cmp_count = 0;
   int wr_cnt = 0;
   initial begin
      forever #12.5 clk_sys_i = ~clk_sys_i;
   end
   pbwc_buttons #(.GAP_N(GAP_US * (CLK_HZ / 1_000_000))) u_btn (.clk_sys_i(clk_sys_i),
      .req_i(req), .step_up_n_o(up_n), .step_down_n_o(dn_n), .store_enable_n_o(se_n),
      .ready_o(ready));
   pbwc_top #(.DEBOUNCE_N(DEB), .HOLD_N(HOLD), .SLOW_N(SLOW), .FAST_N(FAST)) u_dut (
      .clk_sys_i(clk_sys_i), .srst_i(srst_i), .step_up_n_i(up_n), .step_down_n_i(dn_n),
      .store_enable_n_i(se_n), .supply_fail_i(supply_fail_i), .nv_rdata_i(nv_rdata_i),
      .nv_wr_o(nv_wr), .nv_wdata_o(nv_wdata), .wiper_pos_o(wiper_pos), .tap_sel_o(tap_sel),
      .scan_fast_o(scan_fast));
   // Count write strobes; a strobe that stands two cycles counts twice
   always @(posedge clk_sys_i) begin
      if (nv_wr === 1'b1) wr_cnt <= wr_cnt + 1;
   end
   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask
   // Bounded wait for the button model to allow a new push
   task automatic wait_ready();
      int i;
      i = 0;
      while (ready !== 1'b1) begin
         cyc(1);
         i++;
         if (i > 3000) begin
            mismatches++;
            summarize();
         end
      end
   endtask
   // Request bits held for n+1 cycles, then released and left to settle
   task automatic press(input logic [2:0] r, input int n);
      wait_ready();
      @(posedge clk_sys_i);
      req <= r;
      cyc(n);
      @(posedge clk_sys_i);
      req <= 3'h0;
      cyc(20);
   endtask
   task automatic supply_pulse(input int exp);
      int w;
      w = wr_cnt;
      @(posedge clk_sys_i);
      supply_fail_i <= 1'b1;
      cyc(10);
      @(posedge clk_sys_i);
      supply_fail_i <= 1'b0;
      cyc(5);
      check(wr_cnt - w, exp);
   endtask
   task automatic t_reset();
      cyc(8);
      check(wiper_pos, 5'h00);
      check(tap_sel, 32'h0000_0001);
      check(nv_wr, 1'b0);
      check(scan_fast, 1'b0);
      @(posedge clk_sys_i);
      srst_i <= 1'b0;
      cyc(8);
      check(wiper_pos, 5'h1e);
      check(tap_sel, 32'h4000_0000);
   endtask
   task automatic t_steps();
      press(3'h1, 1);
      check(wiper_pos, 5'h1e);
      press(3'h1, 20);
      check(wiper_pos, 5'h1f);
      check(tap_sel, 32'h8000_0000);
      press(3'h1, 60);
      check(wiper_pos, 5'h1f);
   endtask
   // Long down press: slow spacing, then fast spacing, then hold at zero
   task automatic t_scan();
      logic [4:0] prev;
      int last, t, steps;
      logic was_fast;
      prev = wiper_pos;
      last = 0;
      t = 0;
      steps = 0;
      was_fast = 1'b0;
      wait_ready();
      @(posedge clk_sys_i);
      req <= 3'h2;
      while (wiper_pos !== 5'h00 && t < 1000) begin
         cyc(1);
         t++;
         if (wiper_pos !== prev) begin
            check(wiper_pos, prev - 5'h01);
            if (steps > 0 && scan_fast === 1'b0) check(t - last, SLOW);
            if (was_fast && scan_fast === 1'b1) check(t - last, FAST);
            was_fast = (scan_fast === 1'b1);
            prev = wiper_pos;
            last = t;
            steps++;
         end
      end
      // A scan that never reaches the bottom ends the run
      if (t >= 1000) begin
         mismatches++;
         summarize();
      end
      check(steps, 31);
      check(was_fast, 1'b1);
      cyc(50);
      check(wiper_pos, 5'h00);
      check(scan_fast, 1'b1);
      @(posedge clk_sys_i);
      req <= 3'h0;
      cyc(DEB + 10);
      check(scan_fast, 1'b0);
      check(wiper_pos, 5'h00);
   endtask
   // Both low away from the ends, so a step either way would show
   task automatic t_both();
      press(3'h1, 20);
      check(wiper_pos, 5'h01);
      press(3'h3, 60);
      check(wiper_pos, 5'h01);
   endtask
   // Manual save on release; supply loss ignored with store-enable high
   task automatic t_manual();
      int w;
      w = wr_cnt;
      press(3'h4, 20);
      cyc(10);
      check(wr_cnt - w, 1);
      check(nv_wdata, 5'h01);
      supply_pulse(0);
   endtask
   // Store-enable low: supply-loss save, steps locked until it is high again
   task automatic t_lock();
      int w;
      wait_ready();
      @(posedge clk_sys_i);
      req <= 3'h4;
      cyc(30);
      supply_pulse(1);
      check(nv_wdata, 5'h01);
      wait_ready();
      @(posedge clk_sys_i);
      req <= 3'h5;
      cyc(20);
      @(posedge clk_sys_i);
      req <= 3'h4;
      cyc(20);
      check(wiper_pos, 5'h01);
      w = wr_cnt;
      @(posedge clk_sys_i);
      req <= 3'h0;
      cyc(30);
      check(wr_cnt - w, 1);
      press(3'h1, 20);
      check(wiper_pos, 5'h02);
   endtask
   // Mid-run reset with store-enable strapped low: recall, no lock, supply-loss save
   task automatic t_strap();
      wait_ready();
      @(posedge clk_sys_i);
      req <= 3'h4;
      cyc(10);
      @(posedge clk_sys_i);
      srst_i <= 1'b1;
      nv_rdata_i <= 5'h0a;
      cyc(8);
      check(wiper_pos, 5'h00);
      @(posedge clk_sys_i);
      srst_i <= 1'b0;
      cyc(DEB + 8);
      check(wiper_pos, 5'h0a);
      @(posedge clk_sys_i);
      req <= 3'h5;
      cyc(20);
      check(wiper_pos, 5'h0b);
      supply_pulse(1);
      check(nv_wdata, 5'h0b);
      @(posedge clk_sys_i);
      req <= 3'h0;
      cyc(30);
   endtask
   initial begin
      t_reset();
      t_steps();
      t_scan();
      t_both();
      t_manual();
      t_lock();
      t_strap();
      summarize();
   end
endmodule
`default_nettype wire
